//--- pdbg_map.vh
// How it works
// RULE1: Power-down input rising high enables device and resets registers and state machines.
// RULE2: Power-down input low keeps device powered down; pulldown makes it default.
// RULE3: Powered down, all pin outputs tri-stated and PLL shut down.
// RULE4: Host keeps power-down input low until supplies reach required levels.
// RULE5: Self-test pin low disables self-test, high enables; pulldown defaults disabled.
// RULE6: In self-test, clock select low picks pixel clock, high internal 33 MHz.
// RULE7: Shared pin is clock select only in self-test, else interrupt input.
// RULE8: General pins 0..3 reset to general function, driving low; registers pick alternates.
// RULE9: Registers switch general pin 0 to aux serial data or self-test pass.
// RULE10: Registers switch general pin 1 to the aux word clock.
// RULE11: Registers switch general pin 2 to audio data lane c.
// RULE12: Registers switch general pin 3 to audio data lane d.
`ifndef PDBG_MAP_VH
`define PDBG_MAP_VH
`define PDBG_AW           4
`define PDBG_DW           8
`define PDBG_REG_GIO_DATA 4'h0
`define PDBG_REG_GIO_DIR  4'h1
`define PDBG_REG_FUNC0    4'h2
`define PDBG_REG_FUNC1    4'h3
`define PDBG_REG_STATUS   4'h4
`define PDBG_FW           2
`define PDBG_F_GIO        2'h0
`define PDBG_F_ALT_A      2'h1
`define PDBG_F_ALT_B      2'h2
`define PDBG_RST_DATA     4'h0
`define PDBG_RST_DIR      4'h0
`define PDBG_RST_FUNC     8'h00
`define PDBG_ST_OFF       2'h0
`define PDBG_ST_WAKE      2'h1
`define PDBG_ST_RUN       2'h2
`define PDBG_WAKE_CYC     4'h8
`define PDBG_ST_PD        0
`define PDBG_ST_BIST      1
`define PDBG_ST_CSEL      2
`define PDBG_ST_INT       3
`define PDBG_ST_PLL       4
`endif

//--- pdbg_sync.v
`timescale 1ns/10ps
module pdbg_sync (
  clk,
  rst_n,
  d,
  q
);
  input  clk;
  input  rst_n;
  input  d;
  output q;
  wire   clk;
  wire   rst_n;
  wire   d;
  reg    meta_r;
  reg    q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

//--- pdbg_pinmux.v
`timescale 1ns/10ps
`include "pdbg_map.vh"
module pdbg_pinmux (
  clk,
  rst_n,
  en,
  func,
  gio_out,
  gio_dir_in,
  alt_a,
  alt_b,
  pad_o,
  pad_oe_n
);
  input                  clk;
  input                  rst_n;
  input                  en;
  input [`PDBG_FW-1:0]   func;
  input                  gio_out;
  input                  gio_dir_in;
  input                  alt_a;
  input                  alt_b;
  output                 pad_o;
  output                 pad_oe_n;
  wire                   clk;
  wire                   rst_n;
  wire                   en;
  wire   [`PDBG_FW-1:0]  func;
  wire                   gio_out;
  wire                   gio_dir_in;
  wire                   alt_a;
  wire                   alt_b;
  reg                    pad_o;
  reg                    pad_oe_n;
  reg                    o_nxt;
  reg                    oe_n_nxt;

  always @* begin
    o_nxt    = 1'b0;
    oe_n_nxt = 1'b1;
    if (en) begin
      case (func)
        `PDBG_F_ALT_A: begin
          o_nxt    = alt_a;
          oe_n_nxt = 1'b0;
        end
        `PDBG_F_ALT_B: begin
          o_nxt    = alt_b;
          oe_n_nxt = 1'b0;
        end
        default: begin
          o_nxt    = gio_out;
          oe_n_nxt = gio_dir_in;
        end
      endcase
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_o    <= 1'b0;
      pad_oe_n <= 1'b1;
    end else begin
      pad_o    <= o_nxt;
      pad_oe_n <= oe_n_nxt;
    end
  end
endmodule

//--- pdbg_top.v
`timescale 1ns/10ps
`include "pdbg_map.vh"
module pdbg_top (
  clk,
  rst_n,
  power_down_n,
  self_test_enable_pin,
  self_test_clock_select,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  aux_serial_data_out,
  self_test_pass,
  aux_word_clock,
  audio_data_lane_c,
  audio_data_lane_d,
  gio_in,
  gio_o,
  gio_oe_n,
  device_enabled,
  pll_enable,
  lvcmos_oe_n,
  self_test_active,
  self_test_clk_internal,
  interrupt_input
);
  input                  clk;
  input                  rst_n;
  input                  power_down_n;
  input                  self_test_enable_pin;
  input                  self_test_clock_select;
  input [`PDBG_AW-1:0]   reg_addr;
  input [`PDBG_DW-1:0]   reg_wdata;
  input                  reg_wr;
  input                  reg_rd;
  output [`PDBG_DW-1:0]  reg_rdata;
  input                  aux_serial_data_out;
  input                  self_test_pass;
  input                  aux_word_clock;
  input                  audio_data_lane_c;
  input                  audio_data_lane_d;
  input [3:0]            gio_in;
  output [3:0]           gio_o;
  output [3:0]           gio_oe_n;
  output                 device_enabled;
  output                 pll_enable;
  output                 lvcmos_oe_n;
  output                 self_test_active;
  output                 self_test_clk_internal;
  output                 interrupt_input;
  wire                   clk;
  wire                   rst_n;
  wire                   power_down_n;
  wire                   self_test_enable_pin;
  wire                   self_test_clock_select;
  wire   [`PDBG_AW-1:0]  reg_addr;
  wire   [`PDBG_DW-1:0]  reg_wdata;
  wire                   reg_wr;
  wire                   reg_rd;
  reg    [`PDBG_DW-1:0]  reg_rdata;
  wire                   aux_serial_data_out;
  wire                   self_test_pass;
  wire                   aux_word_clock;
  wire                   audio_data_lane_c;
  wire                   audio_data_lane_d;
  wire   [3:0]           gio_in;
  wire   [3:0]           gio_o;
  wire   [3:0]           gio_oe_n;
  reg                    device_enabled;
  reg                    pll_enable;
  reg                    lvcmos_oe_n;
  reg                    self_test_active;
  reg                    self_test_clk_internal;
  reg                    interrupt_input;

  wire                   pd_n_s;
  wire                   bist_s;
  wire                   csel_s;
  wire   [3:0]           gin_s;
  reg    [1:0]           state_r;
  reg    [1:0]           state_nxt;
  reg    [3:0]           wake_cnt_r;
  reg    [3:0]           gio_data_r;
  reg    [3:0]           gio_dir_r;
  reg    [7:0]           func_r;
  reg    [`PDBG_DW-1:0]  rdata_nxt;
  wire                   run;
  wire                   soft_clr;
  wire   [3:0]           alt_a;
  wire   [3:0]           alt_b;
  wire                   wr_data;
  wire                   wr_dir;
  wire                   wr_func0;
  wire                   wr_func1;
  wire   [`PDBG_DW-1:0]  status_w;
  reg                    device_enabled_nxt;
  reg                    pll_enable_nxt;
  reg                    lvcmos_oe_n_nxt;
  reg                    self_test_active_nxt;
  reg                    self_test_clk_internal_nxt;
  reg                    interrupt_input_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Power states, binary coded
  localparam [1:0] ST_OFF  = `PDBG_ST_OFF;
  localparam [1:0] ST_WAKE = `PDBG_ST_WAKE;
  localparam [1:0] ST_RUN  = `PDBG_ST_RUN;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  pdbg_sync u_sync_pd (.clk(clk), .rst_n(rst_n), .d(power_down_n), .q(pd_n_s));
  pdbg_sync u_sync_be (.clk(clk), .rst_n(rst_n), .d(self_test_enable_pin), .q(bist_s));
  pdbg_sync u_sync_cs (.clk(clk), .rst_n(rst_n), .d(self_test_clock_select), .q(csel_s));

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_gin
      pdbg_sync u_sync_g (.clk(clk), .rst_n(rst_n), .d(gio_in[gi]), .q(gin_s[gi]));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Power state machine
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (pd_n_s)
          state_nxt = ST_WAKE; // RULE1
      end
      ST_WAKE: begin
        if (!pd_n_s)
          state_nxt = ST_OFF; // RULE2
        else if (wake_cnt_r == `PDBG_WAKE_CYC)
          state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (!pd_n_s)
          state_nxt = ST_OFF; // RULE2
      end
      default: state_nxt = ST_OFF;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      state_r <= ST_OFF;
    else
      state_r <= state_nxt;
  end

  // Wake delay runs only while waking
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      wake_cnt_r <= 4'h0;
    else if (state_r == ST_WAKE)
      wake_cnt_r <= wake_cnt_r + 4'h1;
    else
      wake_cnt_r <= 4'h0;
  end

  assign run      = (state_r == ST_RUN);
  // Registers held at defaults while off or waking
  assign soft_clr = (state_r != ST_RUN); // RULE1

  ////////////////////////////////////////////////////////////////////////
  // Register write decode
  assign wr_data  = reg_wr & (reg_addr == `PDBG_REG_GIO_DATA);
  assign wr_dir   = reg_wr & (reg_addr == `PDBG_REG_GIO_DIR);
  assign wr_func0 = reg_wr & (reg_addr == `PDBG_REG_FUNC0);
  assign wr_func1 = reg_wr & (reg_addr == `PDBG_REG_FUNC1);

  ////////////////////////////////////////////////////////////////////////
  // Register file, clear wins over a write outside the running state
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      gio_data_r <= `PDBG_RST_DATA;
    else if (soft_clr)
      gio_data_r <= `PDBG_RST_DATA; // RULE8
    else if (wr_data)
      gio_data_r <= reg_wdata[3:0];
  end

  // Direction 0 drives, so pins come up driving low
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      gio_dir_r <= `PDBG_RST_DIR;
    else if (soft_clr)
      gio_dir_r <= `PDBG_RST_DIR; // RULE8
    else if (wr_dir)
      gio_dir_r <= reg_wdata[3:0];
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      func_r <= `PDBG_RST_FUNC;
    end else if (soft_clr) begin
      func_r <= `PDBG_RST_FUNC; // RULE8
    end else begin
      if (wr_func0)
        func_r[3:0] <= reg_wdata[3:0]; // RULE9 RULE10
      if (wr_func1)
        func_r[7:4] <= reg_wdata[3:0]; // RULE11 RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Readback, data stand one cycle after the read strobe
  assign status_w = {3'h0, pll_enable, interrupt_input, self_test_clk_internal,
                     self_test_active, run};

  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `PDBG_REG_GIO_DATA: rdata_nxt = {gin_s, gio_data_r};
      `PDBG_REG_GIO_DIR:  rdata_nxt = {4'h0, gio_dir_r};
      `PDBG_REG_FUNC0:    rdata_nxt = {4'h0, func_r[3:0]};
      `PDBG_REG_FUNC1:    rdata_nxt = {4'h0, func_r[7:4]};
      `PDBG_REG_STATUS:   rdata_nxt = status_w;
      default:            rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Power enables
  always @* begin
    device_enabled_nxt = run; // RULE2
    // PLL starts while waking so it can settle before running
    pll_enable_nxt     = (state_nxt != ST_OFF); // RULE3
    lvcmos_oe_n_nxt    = ~run; // RULE3
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      device_enabled <= 1'b0;
      pll_enable     <= 1'b0;
      lvcmos_oe_n    <= 1'b1;
    end else begin
      device_enabled <= device_enabled_nxt;
      pll_enable     <= pll_enable_nxt;
      lvcmos_oe_n    <= lvcmos_oe_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Self-test mode and shared clock select or interrupt pin
  always @* begin
    self_test_active_nxt       = run & bist_s; // RULE5
    self_test_clk_internal_nxt = run & bist_s & csel_s; // RULE6
    interrupt_input_nxt        = run & ~bist_s & csel_s; // RULE7
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      self_test_active       <= 1'b0;
      self_test_clk_internal <= 1'b0;
      interrupt_input        <= 1'b0;
    end else begin
      self_test_active       <= self_test_active_nxt;
      self_test_clk_internal <= self_test_clk_internal_nxt;
      interrupt_input        <= interrupt_input_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // General pins with alternate functions
  // Alternate B exists only on pin 0; the other pins drive low there
  assign alt_a[0]   = aux_serial_data_out; // RULE9
  assign alt_a[1]   = aux_word_clock; // RULE10
  assign alt_a[2]   = audio_data_lane_c; // RULE11
  assign alt_a[3]   = audio_data_lane_d; // RULE12
  assign alt_b[0]   = self_test_pass; // RULE9
  assign alt_b[3:1] = 3'h0;

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      pdbg_pinmux u_mux (
        .clk        (clk),
        .rst_n      (rst_n),
        .en         (run),
        .func       (func_r[2*gi+1:2*gi]),
        .gio_out    (gio_data_r[gi]),
        .gio_dir_in (gio_dir_r[gi]),
        .alt_a      (alt_a[gi]),
        .alt_b      (alt_b[gi]),
        .pad_o      (gio_o[gi]),
        .pad_oe_n   (gio_oe_n[gi])
      ); // RULE8
    end
  endgenerate
endmodule

//--- pdbg_props.sv
`timescale 1ns/10ps
module pdbg_props (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       power_down_n,
  input wire logic       self_test_enable_pin,
  input wire logic       self_test_clock_select,
  input wire logic [3:0] gio_o,
  input wire logic [3:0] gio_oe_n,
  input wire logic       device_enabled,
  input wire logic       pll_enable,
  input wire logic       lvcmos_oe_n,
  input wire logic       self_test_active,
  input wire logic       self_test_clk_internal,
  input wire logic       interrupt_input
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_steady;
    (device_enabled && $stable(self_test_enable_pin) && $stable(self_test_clock_select))[*5];
  endsequence
  sequence s_pin_low;
    (!power_down_n)[*6];
  endsequence
  a_off_hiz: assert property (!device_enabled && !$past(device_enabled) |->
    lvcmos_oe_n && gio_oe_n == 4'hf && gio_o == 4'h0) else $error("pins driven while off");
  a_pd_off: assert property (s_pin_low |-> !device_enabled && !pll_enable)
    else $error("awake while held down");
  a_wake_wait: assert property ($rose(device_enabled) |-> $past(power_down_n, 8))
    else $error("enabled too early");
  a_wake_bound: assert property (power_down_n[*8] ##1 power_down_n[*8] |-> device_enabled)
    else $error("never enabled");
  a_bist_mode: assert property (s_steady |-> self_test_active == self_test_enable_pin)
    else $error("self test mode wrong");
  a_clk_pick: assert property (s_steady |-> self_test_clk_internal ==
    (self_test_enable_pin && self_test_clock_select)) else $error("clock pick wrong");
  a_int_route: assert property (s_steady |-> interrupt_input ==
    (!self_test_enable_pin && self_test_clock_select)) else $error("interrupt route wrong");
  a_gio_dflt: assert property ($rose(device_enabled) |=>
    gio_oe_n == 4'h0 && gio_o == 4'h0) else $error("gpio not default");
endmodule
bind pdbg_top pdbg_props u_props (.clk, .rst_n, .power_down_n, .self_test_enable_pin,
  .self_test_clock_select, .gio_o, .gio_oe_n, .device_enabled, .pll_enable, .lvcmos_oe_n,
  .self_test_active, .self_test_clk_internal, .interrupt_input);

//--- pdbg_host.sv
`timescale 1ns/10ps
module pdbg_host (
  input  wire logic clk,
  input  wire logic supply_ok,
  input  wire logic on_req,
  input  wire logic bist_req,
  input  wire logic csel_req,
  output logic      power_down_n,
  output logic      self_test_enable_pin,
  output logic      self_test_clock_select
);
  initial begin
    power_down_n = 1'b0;
    self_test_enable_pin = 1'b0;
    self_test_clock_select = 1'b0;
  end
  always @(posedge clk) begin
    power_down_n <= supply_ok & on_req;
    self_test_enable_pin <= bist_req;
    self_test_clock_select <= csel_req;
  end
endmodule

//--- tb_powerdown_bist_gpio_pin_control.sv
`timescale 1ns/10ps
`include "pdbg_map.vh"
module tb_powerdown_bist_gpio_pin_control;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       power_down_n;
  logic       self_test_enable_pin;
  logic       self_test_clock_select;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       aux_serial_data_out, self_test_pass, aux_word_clock;
  logic       audio_data_lane_c, audio_data_lane_d;
  logic [3:0] gio_in = 4'h0;
  logic [3:0] gio_o, gio_oe_n;
  logic       device_enabled, pll_enable, lvcmos_oe_n;
  logic       self_test_active, self_test_clk_internal, interrupt_input;
  logic       supply_ok = 1'b0;
  logic       on_req = 1'b0;
  logic       bist_req = 1'b0;
  logic       csel_req = 1'b0;
  logic [4:0] src = 5'h00;
  int         n_mismatch = 0;
  int         checked = 0;
  assign {aux_serial_data_out, self_test_pass, aux_word_clock, audio_data_lane_c,
          audio_data_lane_d} = src;
  pdbg_host i_host (.clk, .supply_ok, .on_req, .bist_req, .csel_req, .power_down_n,
    .self_test_enable_pin, .self_test_clock_select);
  pdbg_top i_dut (.clk, .rst_n, .power_down_n, .self_test_enable_pin, .self_test_clock_select,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .aux_serial_data_out, .self_test_pass,
    .aux_word_clock, .audio_data_lane_c, .audio_data_lane_d, .gio_in, .gio_o, .gio_oe_n,
    .device_enabled, .pll_enable, .lvcmos_oe_n, .self_test_active, .self_test_clk_internal,
    .interrupt_input);
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  function logic [7:0] pins();
    return {1'b0, pll_enable, device_enabled, lvcmos_oe_n, gio_oe_n};
  endfunction
  task tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task rdc(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rd", reg_rdata, e);
    @(posedge clk);
  endtask
  task run_wait;
    for (int i = 0; i < 40 && device_enabled !== 1'b1; i++) @(posedge clk);
    if (device_enabled !== 1'b1) begin
      n_mismatch++;
      report_and_stop;
    end
    tk(2);
  endtask
  ////////////////////////////////////////////////////////////
  task t_off;
    wr(`PDBG_REG_FUNC0, 8'h05);
    chk("off", pins(), 8'h1f);
    rdc(`PDBG_REG_STATUS, 8'h00);
  endtask
  task t_up;
    supply_ok <= 1'b1;
    run_wait;
    chk("on", pins(), 8'h60);
    rdc(`PDBG_REG_FUNC0, 8'h00);
    rdc(`PDBG_REG_GIO_DIR, 8'h00);
    rdc(`PDBG_REG_STATUS, 8'h11);
  endtask
  task t_gio;
    gio_in <= 4'ha;
    wr(`PDBG_REG_GIO_DIR, 8'hfa);
    wr(`PDBG_REG_GIO_DATA, 8'hf5);
    tk(4);
    chk("gio", {gio_oe_n, gio_o}, 8'ha5);
    rdc(`PDBG_REG_GIO_DATA, 8'ha5);
  endtask
  task t_alt;
    int pn[5] = '{0, 0, 1, 2, 3};
    int fn[5] = '{1, 2, 1, 1, 1};
    int sb[5] = '{4, 3, 2, 1, 0};
    for (int k = 0; k < 5; k++) begin
      wr(4'(2 + pn[k] / 2), 8'(fn[k] << 2 * (pn[k] % 2)));
      for (int b = 0; b < 2; b++) begin
        src <= b ? 5'h01 << sb[k] : ~(5'h01 << sb[k]);
        tk(3);
        chk("alt", {6'h0, gio_oe_n[pn[k]], gio_o[pn[k]]}, 8'(b));
      end
      wr(4'(2 + pn[k] / 2), 8'h00);
    end
    wr(`PDBG_REG_FUNC1, 8'h0f);
    tk(3);
    chk("f3", {4'h0, gio_oe_n[3:2], gio_o[3:2]}, 8'h09);
  endtask
  task t_bist;
    for (int m = 0; m < 4; m++) begin
      bist_req <= m[1];
      csel_req <= m[0];
      tk(8);
      chk("mode", {5'h0, interrupt_input, self_test_clk_internal, self_test_active},
          {5'h0, !m[1] && m[0], m[1] && m[0], m[1]});
      rdc(`PDBG_REG_STATUS, {4'h1, !m[1] && m[0], m[1] && m[0], m[1], 1'b1});
    end
    bist_req <= 1'b0;
    csel_req <= 1'b0;
  endtask
  task t_cycle;
    wr(`PDBG_REG_FUNC1, 8'h05);
    on_req <= 1'b0;
    tk(10);
    chk("down", pins(), 8'h1f);
    on_req <= 1'b1;
    run_wait;
    rdc(`PDBG_REG_FUNC1, 8'h00);
    rdc(`PDBG_REG_GIO_DIR, 8'h00);
    rdc(`PDBG_REG_GIO_DATA, 8'ha0);
    rdc(4'hf, 8'h00);
  endtask
  initial begin
    tk(10);
    rst_n <= 1'b1;
    tk(2);
    on_req <= 1'b1;
    tk(20);
    t_off;
    t_up;
    t_gio;
    t_alt;
    t_bist;
    t_cycle;
    report_and_stop;
  end
endmodule
